//--- hw/spi_id_map.svh
// Opcodes, address fields and timing figures for the flash ID/security host.
// Assumes an mclk of 250 MHz; included by bare name.
`ifndef SPI_ID_MAP_SVH
`define SPI_ID_MAP_SVH
`define MCLK_MHZ 250
`define OPC_WAKE 8'hab
`define OPC_MFR_DEV 8'h90
`define OPC_JEDEC 8'h9f
`define OPC_PARAM 8'h5a
`define OPC_SLEEP 8'hb9
`define OPC_WREN 8'h06
`define OPC_STATUS 8'h05
`define OPC_SR_ERASE 8'h44
`define OPC_SR_PROG 8'h42
`define SR1_HI 8'h10
`define SR2_HI 8'h20
`define SR3_HI 8'h30
`define STATUS_BUSY_BIT 0
`define WAKE_ID_DUMMY 3
`define PARAM_DUMMY 1
`define SCK_HALF 4
`define WAKE_DELAY_NS 3000
`define WAKE_WITH_ID_DELAY_NS 1800
`define CS_HIGH_NS 50
`endif

//--- hw/spi_id_pkg.sv
// Types for the flash ID/security host: command, response and frame carriers.
// Assumes nothing else; every user writes spi_id_pkg::name.
`default_nettype none
package spi_id_pkg;
  typedef enum logic [2:0] {
    OP_WAKE, OP_WAKE_ID, OP_MFR_DEV, OP_JEDEC, OP_PARAM, OP_SLEEP, OP_ERASE, OP_PROG
  } op_t;
  typedef struct packed {
    op_t op;
    logic [23:0] addr;
    logic [8:0] count;
  } cmd_t;
  typedef struct packed {
    logic err;
    logic [7:0] status;
  } rsp_t;
  typedef struct packed {
    logic [4:0][7:0] hdr;
    logic [2:0] len;
    logic [8:0] left;
    logic wr;
    logic poll;
  } frame_t;
  typedef enum logic [1:0] {ST_IDLE, ST_FRAME, ST_GAP} state_t;
endpackage : spi_id_pkg
`default_nettype wire

//--- hw/byte_fifo.sv
// Small flop FIFO for program data, valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic in_valid,
  output var logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output var logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("byte_fifo: DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0] cnt_q, cnt_d;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  assign out_data = mem_q[rp_q];
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
      cnt_q <= cnt_d;
      // Flags kept as flops so ready never depends on the sink combinationally
      in_ready <= cnt_d != (AW+1)'(DEPTH);
      out_valid <= cnt_d != '0;
    end
  end
  always_ff @(posedge mclk) begin
    if (push) mem_q[wp_q] <= in_data;
  end
endmodule : byte_fifo
`default_nettype wire

//--- hw/spi_id_host.sv
// Host controller for a serial flash: ID reads, wake/sleep, security register
// erase and program. Assumes SPI mode 0 and a device answering on miso.
// How it works
// RULE_01 - Wake: opcode alone, then wait wake delay
// RULE_02 - Keep select high through wake delay
// RULE_03 - Wake-ID: opcode, three dummies, then ID
// RULE_04 - ID repeats while clocking; select ends
// RULE_05 - Wake-with-ID from sleep: hold second delay
// RULE_06 - Device ignores wake/ID while busy
// RULE_07 - Maker/device ID: opcode, zero address, two bytes
// RULE_08 - Address one swaps the two ID bytes
// RULE_09 - Maker/device bytes alternate until select rises
// RULE_10 - Standard ID: three bytes, no address
// RULE_11 - Parameter read: address, eight dummy clocks
// RULE_12 - Parameter address bits 23..8 zero
// RULE_13 - Parameter read also reaches unique serial
// RULE_14 - Security erase needs write enable first
// RULE_15 - Erase address selects register one to three
// RULE_16 - Select rises right after last address bit
// RULE_17 - Erase self-timed; busy polled until clear
// RULE_18 - Device clears write enable after erase
// RULE_19 - Locked register ignores erase
// RULE_20 - Locked register ignores program
// RULE_21 - Program: enable, address, 1..256 data bytes
// RULE_22 - Select stays low through all program data
// RULE_23 - Asleep: only wake command accepted
// RULE_24 - Program self-timed like erase
`include "spi_id_map.svh"
`default_nettype none
module spi_id_host #(
  parameter int SCK_HALF = `SCK_HALF,
  parameter int WAKE_DELAY_NS = `WAKE_DELAY_NS,
  parameter int WAKE_WITH_ID_DELAY_NS = `WAKE_WITH_ID_DELAY_NS,
  parameter int FIFO_DEPTH = 4
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic cmd_valid,
  output var logic cmd_ready,
  input wire spi_id_pkg::cmd_t cmd,
  input wire logic wdata_valid,
  output var logic wdata_ready,
  input wire logic [7:0] wdata,
  output var logic rdata_valid,
  output logic [7:0] rdata,
  output var logic rsp_valid,
  output var spi_id_pkg::rsp_t rsp,
  output var logic asleep,
  output var logic cs_n,
  output var logic sck,
  output var logic mosi,
  input wire logic miso
);
  localparam int DIVW = $clog2(2 * SCK_HALF);
  localparam int WAKE_CYC = (WAKE_DELAY_NS * `MCLK_MHZ + 999) / 1000;
  localparam int WAKE_ID_CYC = (WAKE_WITH_ID_DELAY_NS * `MCLK_MHZ + 999) / 1000;
  localparam int GAP_RAW = (`CS_HIGH_NS * `MCLK_MHZ + 999) / 1000;
  localparam int GAP_CYC = GAP_RAW < 1 ? 1 : GAP_RAW;
  initial begin
    // Sampling sits two cycles after the rise, behind the synchroniser
    if (SCK_HALF < 4) $error("spi_id_host: SCK_HALF must be at least 4");
    if (WAKE_CYC >= 65536 || WAKE_ID_CYC >= 65536) $error("spi_id_host: delay too long");
  end

  spi_id_pkg::state_t state_q;
  spi_id_pkg::cmd_t cmd_q;
  spi_id_pkg::frame_t frm_q;
  logic [1:0] stage_q;
  logic [2:0] idx_q, bit_q;
  logic [DIVW-1:0] div_q;
  logic [7:0] tx_q, rx_q;
  logic [15:0] timer_q;
  logic wait_q, rd_phase_q, miso_m_q, miso_s_q;
  logic f_valid, f_ready;
  logic [7:0] f_data;

  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .reset_n(reset_n),
    .in_valid(wdata_valid),
    .in_ready(wdata_ready),
    .in_data(wdata),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  // Builds the bytes sent before the data phase for each step of a command
  function automatic spi_id_pkg::frame_t build(spi_id_pkg::cmd_t c, logic [1:0] stage);
    spi_id_pkg::frame_t f;
    f = '0;
    f.hdr[1] = c.addr[23:16];
    f.hdr[2] = c.addr[15:8];
    f.hdr[3] = c.addr[7:0];
    f.len = 3'd4;
    f.left = c.count;
    if (stage == 2'd0) begin
      f.hdr[0] = `OPC_WREN; // RULE_14 RULE_21
      f.len = 3'd1;
      f.left = '0;
    end else if (stage == 2'd2) begin
      f.hdr[0] = `OPC_STATUS; // RULE_17 RULE_24
      f.len = 3'd1;
      f.left = 9'd1;
      f.poll = 1'b1;
    end else begin
      case (c.op)
        spi_id_pkg::OP_WAKE: begin
          f.hdr[0] = `OPC_WAKE; // RULE_01
          f.len = 3'd1;
          f.left = '0;
        end
        spi_id_pkg::OP_WAKE_ID: begin
          f.hdr[0] = `OPC_WAKE; // RULE_03
          f.hdr[3:1] = '0;
          f.len = 3'(1 + `WAKE_ID_DUMMY);
        end
        spi_id_pkg::OP_MFR_DEV: f.hdr[0] = `OPC_MFR_DEV; // RULE_07
        spi_id_pkg::OP_JEDEC: begin
          f.hdr[0] = `OPC_JEDEC; // RULE_10
          f.len = 3'd1;
        end
        spi_id_pkg::OP_PARAM: begin
          f.hdr[0] = `OPC_PARAM; // RULE_11 RULE_13
          f.len = 3'(4 + `PARAM_DUMMY);
        end
        spi_id_pkg::OP_SLEEP: begin
          f.hdr[0] = `OPC_SLEEP;
          f.len = 3'd1;
          f.left = '0;
        end
        spi_id_pkg::OP_ERASE: begin
          f.hdr[0] = `OPC_SR_ERASE; // RULE_16
          f.left = '0;
        end
        default: begin
          f.hdr[0] = `OPC_SR_PROG; // RULE_21
          f.wr = 1'b1;
        end
      endcase
    end
    return f;
  endfunction : build

  // Command screening
  wire is_erase = cmd.op == spi_id_pkg::OP_ERASE;
  wire is_prog = cmd.op == spi_id_pkg::OP_PROG;
  wire is_wake = cmd.op == spi_id_pkg::OP_WAKE || cmd.op == spi_id_pkg::OP_WAKE_ID;
  wire sec_hi_ok = cmd.addr[23:16] == 8'h00 && (cmd.addr[15:8] == `SR1_HI ||
    cmd.addr[15:8] == `SR2_HI || cmd.addr[15:8] == `SR3_HI); // RULE_15
  wire needs_count = cmd.op != spi_id_pkg::OP_WAKE && cmd.op != spi_id_pkg::OP_SLEEP &&
    !is_erase;
  wire addr_ok = (cmd.op == spi_id_pkg::OP_MFR_DEV) ? cmd.addr[23:1] == '0 : // RULE_07 RULE_08
    (cmd.op == spi_id_pkg::OP_PARAM) ? cmd.addr[23:8] == '0 : // RULE_12
    (is_erase || is_prog) ? sec_hi_ok : 1'b1;
  wire count_ok = !needs_count || (cmd.count != '0 && !(is_prog && cmd.count > 9'd256));
  wire cmd_bad = !addr_ok || !count_ok || (asleep && !is_wake); // RULE_23
  wire cmd_take = cmd_valid && cmd_ready;

  // Bit timing
  wire bit_end = state_q == spi_id_pkg::ST_FRAME && !wait_q &&
    div_q == DIVW'(2 * SCK_HALF - 1);
  wire byte_end = bit_end && bit_q == 3'd0;
  wire sample = state_q == spi_id_pkg::ST_FRAME && !wait_q && div_q == DIVW'(SCK_HALF + 2);
  wire hdr_more = idx_q < frm_q.len;
  wire data_more = frm_q.left != '0;
  wire load_stall = frm_q.wr && !hdr_more && data_more && !f_valid; // RULE_22
  wire loading = state_q == spi_id_pkg::ST_FRAME && wait_q && (hdr_more || data_more) &&
    !load_stall;
  wire frame_end = state_q == spi_id_pkg::ST_FRAME && wait_q && !hdr_more && !data_more;
  wire [7:0] next_tx = hdr_more ? frm_q.hdr[idx_q] : (frm_q.wr ? f_data : 8'h00);
  wire status_busy = rx_q[`STATUS_BUSY_BIT];
  wire gap_done = state_q == spi_id_pkg::ST_GAP && timer_q == '0;
  wire two_step = cmd_q.op == spi_id_pkg::OP_ERASE || cmd_q.op == spi_id_pkg::OP_PROG;
  wire [15:0] gap_len = (stage_q == 2'd1 && cmd_q.op == spi_id_pkg::OP_WAKE) ? 16'(WAKE_CYC) :
    (stage_q == 2'd1 && cmd_q.op == spi_id_pkg::OP_WAKE_ID && asleep) ? 16'(WAKE_ID_CYC) :
    16'(GAP_CYC - 1); // RULE_01 RULE_02 RULE_05
  wire finish = gap_done && (stage_q == 2'd2 ? !status_busy : (stage_q == 2'd1 && !two_step));
  wire [1:0] next_stage = stage_q == 2'd0 ? 2'd1 : 2'd2;
  assign f_ready = loading && !hdr_more && frm_q.wr;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      miso_m_q <= 1'b0;
      miso_s_q <= 1'b0;
    end else begin
      miso_m_q <= miso;
      miso_s_q <= miso_m_q;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= spi_id_pkg::ST_IDLE;
      cmd_q <= '0;
      frm_q <= '0;
      stage_q <= 2'd0;
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp <= '0;
      asleep <= 1'b0;
      timer_q <= '0;
    end else begin
      rsp_valid <= 1'b0;
      cmd_ready <= state_q == spi_id_pkg::ST_IDLE && !cmd_take && !finish;
      if (cmd_take && cmd_bad) begin
        rsp_valid <= 1'b1;
        rsp <= '{err: 1'b1, status: 8'h00};
      end else if (cmd_take) begin
        cmd_q <= cmd;
        stage_q <= (is_erase || is_prog) ? 2'd0 : 2'd1; // RULE_14
        frm_q <= build(cmd, (is_erase || is_prog) ? 2'd0 : 2'd1);
        state_q <= spi_id_pkg::ST_FRAME;
      end
      if (frame_end) begin
        state_q <= spi_id_pkg::ST_GAP;
        timer_q <= gap_len;
      end
      if (state_q == spi_id_pkg::ST_GAP && timer_q != '0) timer_q <= timer_q - 16'd1;
      if (finish) begin
        state_q <= spi_id_pkg::ST_IDLE;
        rsp_valid <= 1'b1;
        rsp <= '{err: 1'b0, status: stage_q == 2'd2 ? rx_q : 8'h00};
        if (cmd_q.op == spi_id_pkg::OP_SLEEP) asleep <= 1'b1;
        if (cmd_q.op == spi_id_pkg::OP_WAKE || cmd_q.op == spi_id_pkg::OP_WAKE_ID) asleep <= 1'b0;
      end else if (gap_done) begin
        // Next step: the command after write enable, the first status poll, or another poll while busy is set
        stage_q <= next_stage; // RULE_17 RULE_24
        frm_q <= build(cmd_q, next_stage);
        state_q <= spi_id_pkg::ST_FRAME;
      end
      if (loading && !hdr_more) frm_q.left <= frm_q.left - 9'd1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      idx_q <= 3'd0;
      bit_q <= 3'd7;
      div_q <= '0;
      tx_q <= 8'h00;
      rx_q <= 8'h00;
      wait_q <= 1'b1;
      rd_phase_q <= 1'b0;
      cs_n <= 1'b1;
      sck <= 1'b0;
      mosi <= 1'b0;
      rdata_valid <= 1'b0;
      rdata <= 8'h00;
    end else begin
      rdata_valid <= byte_end && rd_phase_q && !frm_q.poll; // RULE_04 RULE_09
      if (byte_end) rdata <= rx_q;
      if (sample) rx_q <= {rx_q[6:0], miso_s_q};
      if (state_q != spi_id_pkg::ST_FRAME) begin
        idx_q <= 3'd0;
        wait_q <= 1'b1;
        cs_n <= 1'b1;
        sck <= 1'b0;
      end else if (wait_q) begin
        cs_n <= frame_end; // RULE_16
        if (loading) begin
          tx_q <= next_tx;
          mosi <= next_tx[7];
          idx_q <= hdr_more ? idx_q + 3'd1 : idx_q;
          rd_phase_q <= !hdr_more && !frm_q.wr;
          bit_q <= 3'd7;
          div_q <= '0;
          wait_q <= 1'b0;
        end
      end else begin
        div_q <= bit_end ? '0 : div_q + 1'b1;
        sck <= div_q >= DIVW'(SCK_HALF - 1) && !bit_end;
        if (bit_end) begin
          bit_q <= bit_q - 3'd1;
          wait_q <= bit_q == 3'd0;
          if (bit_q != 3'd0) mosi <= tx_q[bit_q - 3'd1];
        end
      end
    end
  end

  // Checking helpers
  logic [15:0] hi_cnt_q;
  logic [2:0] edge_cnt_q;
  logic last_wake_q, last_wake_id_q, wren_done_q;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hi_cnt_q <= '0;
      edge_cnt_q <= '0;
      last_wake_q <= 1'b0;
      last_wake_id_q <= 1'b0;
      wren_done_q <= 1'b0;
    end else begin
      hi_cnt_q <= cs_n ? (hi_cnt_q == 16'hffff ? hi_cnt_q : hi_cnt_q + 16'd1) : '0;
      if (sck && !$past(sck)) edge_cnt_q <= edge_cnt_q + 3'd1;
      if (frame_end) begin
        last_wake_q <= stage_q == 2'd1 && cmd_q.op == spi_id_pkg::OP_WAKE;
        last_wake_id_q <= stage_q == 2'd1 && cmd_q.op == spi_id_pkg::OP_WAKE_ID && asleep;
        wren_done_q <= stage_q == 2'd0;
      end
    end
  end

  property p_wake_gap;
    @(posedge mclk) disable iff (!reset_n) $fell(cs_n) && last_wake_q |-> hi_cnt_q >= WAKE_CYC;
  endproperty
  a_wake_gap: assert property (p_wake_gap) else $error("wake delay cut short"); // RULE_02
  property p_wake_id_gap;
    @(posedge mclk) disable iff (!reset_n)
      $fell(cs_n) && last_wake_id_q |-> hi_cnt_q >= WAKE_ID_CYC;
  endproperty
  a_wake_id_gap: assert property (p_wake_id_gap) else $error("second delay cut"); // RULE_05
  property p_byte_whole;
    @(posedge mclk) disable iff (!reset_n) $rose(cs_n) |-> edge_cnt_q == 3'd0 && !sck;
  endproperty
  a_byte_whole: assert property (p_byte_whole) else $error("select rose mid byte"); // RULE_16
  property p_prog_hold;
    @(posedge mclk) disable iff (!reset_n) load_stall && wait_q |=> !cs_n [*2];
  endproperty
  a_prog_hold: assert property (p_prog_hold) else $error("select rose in data"); // RULE_22
  property p_wren_first;
    @(posedge mclk) disable iff (!reset_n)
      loading && idx_q == 3'd0 && stage_q == 2'd1 && two_step |-> wren_done_q;
  endproperty
  a_wren_first: assert property (p_wren_first) else $error("no write enable"); // RULE_14
  property p_param_addr;
    @(posedge mclk) disable iff (!reset_n)
      cmd_take && !cmd_bad && cmd.op == spi_id_pkg::OP_PARAM |-> cmd.addr[23:8] == '0;
  endproperty
  a_param_addr: assert property (p_param_addr) else $error("bad table address"); // RULE_12
  property p_id_addr;
    @(posedge mclk) disable iff (!reset_n)
      cmd_take && cmd.op == spi_id_pkg::OP_MFR_DEV && cmd.addr > 24'd1 |=> rsp_valid && rsp.err;
  endproperty
  a_id_addr: assert property (p_id_addr) else $error("bad id address"); // RULE_07
  property p_erase_addr;
    @(posedge mclk) disable iff (!reset_n)
      cmd_take && is_erase && !sec_hi_ok |=> rsp_valid && rsp.err && state_q == spi_id_pkg::ST_IDLE;
  endproperty
  a_erase_addr: assert property (p_erase_addr) else $error("bad erase address"); // RULE_15
  property p_sleep_only_wake;
    @(posedge mclk) disable iff (!reset_n) asleep && cmd_take && !is_wake |=> rsp.err;
  endproperty
  a_sleep_only_wake: assert property (p_sleep_only_wake) else $error("cmd while asleep"); // RULE_23
  property p_poll_busy;
    @(posedge mclk) disable iff (!reset_n)
      gap_done && stage_q == 2'd2 && status_busy |=> state_q == spi_id_pkg::ST_FRAME && !rsp_valid;
  endproperty
  a_poll_busy: assert property (p_poll_busy) else $error("busy not polled"); // RULE_17
  c_erase: cover property (@(posedge mclk) finish && cmd_q.op == spi_id_pkg::OP_ERASE);
  c_prog: cover property (@(posedge mclk) finish && cmd_q.op == spi_id_pkg::OP_PROG);
  c_wake_id: cover property (@(posedge mclk) rdata_valid && cmd_q.op == spi_id_pkg::OP_WAKE_ID);
endmodule : spi_id_host
`default_nettype wire

//--- testbench/flash_id_model.sv
// Behavioural serial flash: IDs, parameter table, lockable security registers.
// Assumes mode 0 from the host; miso has no pull, so undriven bits toggle.
`default_nettype none
module flash_id_model #(
  parameter logic [7:0] MFR = 8'h11,
  parameter logic [7:0] DEV = 8'h22,
  parameter logic [7:0] TYP = 8'h33,
  parameter logic [7:0] CAP = 8'h44,
  parameter logic [63:0] UID = 64'h0,
  parameter logic [3:0] LOCK = 4'b1000,
  parameter int WAKE_DELAY = 400,
  parameter int WAKE_ID_DELAY = 300,
  parameter int TBUSY = 2000
) (
  input wire logic cs_n,
  input wire logic sck,
  input wire logic mosi,
  output var logic miso
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sreg [0:3][0:255];
  logic [7:0] sh, op, b;
  logic [23:0] ad;
  logic [7:0] pg [$];
  logic asleep = 1'b0, busy = 1'b0, wr_en_latch = 1'b0, ign = 1'b0;
  realtime ready_at = 0;
  int bits = 0, ds, x;
  wire [1:0] r = ad[13:12];
  wire ok = ad[23:16] == 8'h00 && ad[15:8] inside {8'h10, 8'h20, 8'h30};
  wire live = !ign && (!asleep || op == 8'hab) && (!busy || op == 8'h05);
  initial begin
    miso = 1'b0;
    foreach (sreg[i, j]) sreg[i][j] = (i == 3) ? 8'ha5 : 8'hff;
  end
  function automatic logic [7:0] rd(input int n);
    case (op)
      8'hab: return DEV;
      8'h90: return (ad[0] ^ n[0]) ? DEV : MFR;
      8'h9f: return (n == 0) ? MFR : (n == 1) ? TYP : CAP;
      8'h5a: return tbl(ad[7:0] + n[7:0]);
      default: return {6'h00, wr_en_latch, busy};
    endcase
  endfunction : rd
  // Serial number sits in the top eight table bytes, read-only
  function automatic logic [7:0] tbl(input logic [7:0] a);
    return (a[7:3] == 5'h1f) ? UID[8 * (7 - a[2:0]) +: 8] : a ^ 8'h3c;
  endfunction : tbl
  always @(negedge cs_n) begin
    bits = 0;
    op = 8'h00;
    pg.delete();
    ign = ($realtime < ready_at);
  end
  always @(posedge sck) if (!cs_n) begin
    sh = {sh[6:0], mosi};
    bits++;
    if (bits == 8) op = sh;
    else if (bits <= 32 && bits % 8 == 0) ad = {ad[15:0], sh};
    else if (bits % 8 == 0) pg.push_back(sh);
  end
  always @(negedge sck) if (!cs_n) begin
    ds = (op == 8'h9f || op == 8'h05) ? 8 : (op == 8'h5a) ? 40 : 32;
    x = bits - ds;
    b = rd(x / 8);
    if (live && x >= 0 && op inside {8'hab, 8'h90, 8'h9f, 8'h5a, 8'h05}) miso = b[7 - x % 8];
    else miso = ~miso;
  end
  always @(posedge cs_n) begin
    miso = ~miso;
    if (live && bits > 0) begin
      if (op == 8'hab && asleep) begin
        asleep = 1'b0;
        ready_at = $realtime + ((bits > 8) ? WAKE_ID_DELAY : WAKE_DELAY);
      end
      if (op == 8'hb9 && bits == 8) asleep = 1'b1;
      if (op == 8'h06 && bits == 8) wr_en_latch = 1'b1;
      if (op == 8'h44 && bits == 32 && wr_en_latch && ok && !LOCK[r]) begin
        for (int i = 0; i < 256; i++) sreg[r][i] = 8'hff;
        busy = 1'b1;
      end
      if (op == 8'h42 && bits > 32 && bits % 8 == 0 && wr_en_latch && ok && !LOCK[r]) begin
        foreach (pg[i]) sreg[r][8'(ad[7:0] + i)] &= pg[i];
        busy = 1'b1;
      end
    end
  end
  always @(posedge busy) begin
    #TBUSY;
    busy = 1'b0;
    wr_en_latch = 1'b0;
  end
endmodule : flash_id_model
`default_nettype wire

//--- testbench/spi_id_host_tb_top.sv
// Bench for the flash ID/security host: random and corner commands.
// Assumes the behavioural flash model on the far side of the SPI pins.
`default_nettype none
module spi_id_host_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] MFR = 8'h5e; // Arbitrary value
  localparam logic [7:0] DEV = 8'h2c; // Arbitrary value
  localparam logic [7:0] TYP = 8'h71; // Arbitrary value
  localparam logic [7:0] CAP = 8'h17; // Arbitrary value
  localparam logic [63:0] UID = 64'h0123_4567_89ab_cdef; // Arbitrary value
  logic mclk, reset_n, cmd_valid, cmd_ready, wdata_valid, wdata_ready, rdata_valid;
  logic rsp_valid, asleep, cs_n, sck, mosi, miso;
  logic [7:0] wdata, rdata;
  spi_id_pkg::cmd_t cmd;
  spi_id_pkg::rsp_t rsp;
  logic [7:0] rxq [$], eq [$], fq [$];
  int errors, num_checks, cyc, frames, fi;
  integer seed;
  // Short wake delays keep the run brief; the model uses the same figures
  spi_id_host #(.WAKE_DELAY_NS(400), .WAKE_WITH_ID_DELAY_NS(300)) DUT (
    .mclk(mclk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd(cmd), .wdata_valid(wdata_valid), .wdata_ready(wdata_ready), .wdata(wdata),
    .rdata_valid(rdata_valid), .rdata(rdata), .rsp_valid(rsp_valid), .rsp(rsp),
    .asleep(asleep), .cs_n(cs_n), .sck(sck), .mosi(mosi), .miso(miso));
  flash_id_model #(.MFR(MFR), .DEV(DEV), .TYP(TYP), .CAP(CAP), .UID(UID)) u_flash (
    .cs_n(cs_n), .sck(sck), .mosi(mosi), .miso(miso));
  always #2 mclk = ~mclk;
  always @(negedge cs_n) frames++;
  always @(posedge mclk) if (rdata_valid === 1'b1) rxq.push_back(rdata);
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 80000) begin
      errors++;
      tally_and_finish();
    end
  end
  // Feeder gaps are random, but prog fills the FIFO for 60 cycles first, so the host does not meet it empty mid-program
  always @(posedge mclk) begin
    if (wdata_valid && wdata_ready) begin
      wdata_valid <= 1'b0;
      fi <= fi + 1;
    end else if (!wdata_valid && fi < fq.size() && $random(seed) % 3 == 0) begin
      wdata_valid <= 1'b1;
      wdata <= fq[fi];
    end
  end
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic run(input spi_id_pkg::op_t op, input logic [23:0] a, input logic [8:0] n);
    int t;
    t = 0;
    rxq.delete();
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd <= '{op, a, n};
    @(negedge mclk);
    while (cmd_ready !== 1'b1) @(negedge mclk);
    @(posedge mclk);
    cmd_valid <= 1'b0;
    do begin
      @(negedge mclk);
      t++;
    end while (rsp_valid !== 1'b1 && t < 20000);
    chk("response", t < 20000, 1'b1);
    @(negedge mclk);
  endtask : run
  task automatic rd_cmd(input spi_id_pkg::op_t op, input logic [23:0] a, input logic [8:0] n);
    run(op, a, n);
    chk("read_err", rsp.err, 1'b0);
    chk("read_len", rxq.size(), n);
    foreach (eq[i]) chk("read_byte", rxq[i], eq[i]);
  endtask : rd_cmd
  task automatic refuse(input spi_id_pkg::op_t op, input logic [23:0] a, input logic [8:0] n);
    int f;
    f = frames;
    run(op, a, n);
    chk("refused", rsp.err, 1'b1);
    chk("frames", frames, f);
  endtask : refuse
  task automatic prog(input logic [23:0] a, input int n);
    int k;
    fq.delete();
    fi = 0;
    for (k = 0; k < n; k++) fq.push_back(8'($random(seed)));
    repeat (60) @(posedge mclk);
    if (n > 4) chk("fifo_full", wdata_ready, 1'b0);
    run(spi_id_pkg::OP_PROG, a, 9'(n));
    chk("prog_err", rsp.err, 1'b0);
    chk("prog_busy", rsp.status[0], 1'b0);
    for (k = 0; k < n; k++)
      chk("prog_mem", u_flash.sreg[a[13:12]][8'(a[7:0] + k)], (a[13:12] == 3) ? 8'ha5 : fq[k]);
  endtask : prog
  task automatic erase(input logic [23:0] a);
    run(spi_id_pkg::OP_ERASE, a, 9'd0);
    chk("erase_err", rsp.err, 1'b0);
    chk("erase_busy", rsp.status[0], 1'b0);
    for (int k = 0; k < 256; k += 17)
      chk("erase_mem", u_flash.sreg[a[13:12]][k], (a[13:12] == 3) ? 8'ha5 : 8'hff);
  endtask : erase
  function automatic logic [7:0] exp_tbl(input logic [7:0] a);
    return (a[7:3] == 5'h1f) ? UID[8 * (7 - a[2:0]) +: 8] : a ^ 8'h3c;
  endfunction : exp_tbl
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  initial begin
    int n;
    logic [7:0] a;
    seed = 49280;
    mclk = 1'b0;
    reset_n = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    wdata_valid = 1'b0;
    wdata = 8'h00;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    eq = '{MFR, TYP, CAP};
    rd_cmd(spi_id_pkg::OP_JEDEC, 24'h0, 9'd3);
    for (int k = 0; k < 2; k++) begin
      eq.delete();
      for (int j = 0; j < 5; j++) eq.push_back(((k ^ j) & 1) ? DEV : MFR);
      rd_cmd(spi_id_pkg::OP_MFR_DEV, 24'(k), 9'd5);
    end
    refuse(spi_id_pkg::OP_MFR_DEV, 24'h000002, 9'd2);
    eq = '{DEV, DEV, DEV};
    rd_cmd(spi_id_pkg::OP_WAKE_ID, 24'h0, 9'd3);
    for (int k = 0; k < 6; k++) begin
      a = (k == 0) ? 8'hf8 : 8'($random(seed));
      n = (k == 0) ? 8 : 1 + ($random(seed) & 7);
      eq.delete();
      for (int j = 0; j < n; j++) eq.push_back(exp_tbl(8'(a + j)));
      rd_cmd(spi_id_pkg::OP_PARAM, {16'h0, a}, 9'(n));
    end
    refuse(spi_id_pkg::OP_PARAM, 24'h000100, 9'd1);
    run(spi_id_pkg::OP_SLEEP, 24'h0, 9'd0);
    chk("asleep", asleep, 1'b1);
    refuse(spi_id_pkg::OP_JEDEC, 24'h0, 9'd3);
    run(spi_id_pkg::OP_WAKE, 24'h0, 9'd0);
    chk("awake", asleep, 1'b0);
    eq = '{MFR, TYP, CAP};
    rd_cmd(spi_id_pkg::OP_JEDEC, 24'h0, 9'd3);
    run(spi_id_pkg::OP_SLEEP, 24'h0, 9'd0);
    eq = '{DEV, DEV};
    rd_cmd(spi_id_pkg::OP_WAKE_ID, 24'h0, 9'd2);
    eq = '{MFR, TYP, CAP};
    rd_cmd(spi_id_pkg::OP_JEDEC, 24'h0, 9'd3);
    prog(24'h001010, 6);
    chk("latch_prog", u_flash.wr_en_latch, 1'b0);
    erase(24'h0010a7);
    chk("latch_erase", u_flash.wr_en_latch, 1'b0);
    prog(24'h002000, 3);
    prog(24'h003004, 5);
    erase(24'h003000);
    refuse(spi_id_pkg::OP_ERASE, 24'h004000, 9'd0);
    refuse(spi_id_pkg::OP_ERASE, 24'h011000, 9'd0);
    refuse(spi_id_pkg::OP_PROG, 24'h001000, 9'd0);
    refuse(spi_id_pkg::OP_PROG, 24'h001000, 9'd257);
    tally_and_finish();
  end
endmodule : spi_id_host_tb_top
`default_nettype wire
